// >>> pkg/pmc_pkg.sv
// Package with register map, field layout and shared types of the clock and power mode block
package pmc_pkg;

   // Register addresses
   localparam logic [7:0] POWER_MODE_CONTROL_ADDR = 8'h87;
   localparam logic [7:0] PORT_PIN_WAKE_ENABLE_ADDR = 8'h96;
   localparam logic [7:0] CLOCK_SELECT_CONTROL_ADDR = 8'hd8;
   localparam logic [7:0] FAST_OSC_TRIM_ADDR = 8'hf6;
   localparam logic [7:0] AUXILIARY_CONTROL_TWO_ADDR = 8'hf7;

   // power_mode_control fields
   localparam int IDLE_REQUEST_BIT = 0;
   localparam int STOP_REQUEST_BIT = 1;
   localparam logic [7:0] POWER_MODE_KEEP_MASK = 8'h8c;
   localparam logic [7:0] POWER_MODE_CONTROL_RESET = 8'h00;

   // clock_select_control fields
   localparam int SYSCLK_DIVIDER_LSB = 0;
   localparam int FAST_CLOCK_SELECT_BIT = 2;
   localparam int FAST_OSC_STOP_BIT = 3;
   localparam int IDLE_PERIPH_CLOCK_GATE_BIT = 4;
   localparam logic [1:0] SYSCLK_DIVIDER_RESET = 2'h3;

   // System clock divider codes
   localparam logic [1:0] DIV_BY_16 = 2'h0;
   localparam logic [1:0] DIV_BY_4 = 2'h1;
   localparam logic [1:0] DIV_BY_2 = 2'h2;
   localparam logic [1:0] DIV_BY_1 = 2'h3;
   localparam int DIV_LATENCY_CYCLES = 16;

   // fast_osc_trim, auxiliary_control_two and port_pin_wake_enable
   localparam int TRIM_WIDTH = 7;
   localparam int WATCHDOG_RESET_MODE_LSB = 6;
   localparam logic [1:0] WATCHDOG_ALWAYS = 2'h3;
   localparam logic [7:0] AUXILIARY_CONTROL_TWO_RESET = 8'h06;
   localparam logic [7:0] PORT_PIN_WAKE_ENABLE_RESET = 8'h00;

   // Oscillator nominal frequencies in Hz
   localparam int FAST_INTERNAL_OSC_HZ = 16588000;
   localparam int SLOW_INTERNAL_OSC_HZ = 80000;

   // Reported mode, one-hot
   localparam logic [3:0] MODE_FAST = 4'h1;
   localparam logic [3:0] MODE_SLOW = 4'h2;
   localparam logic [3:0] MODE_IDLE = 4'h4;
   localparam logic [3:0] MODE_STOP = 4'h8;

   typedef enum logic [2:0]
   {
      PM_RUN = 3'b001,
      PM_IDLE = 3'b010,
      PM_STOP = 3'b100
   } pmc_state_type;

   typedef struct packed
   {
      logic cpu;
      logic periph;
      logic timer3;
      logic wdt;
      logic fast_osc;
      logic slow_osc;
   } pmc_clk_en_type;

   // Slow mode out of reset: all running except the watchdog
   localparam pmc_clk_en_type CLK_EN_RESET = 6'h3b;

endpackage : pmc_pkg

// >>> logic/pmc_sysclk_div.sv
// System clock divider: divides source ticks by 1, 2, 4 or 16
`timescale 1ns/1ps
`default_nettype none
module pmc_sysclk_div
   import pmc_pkg::*;
#(
   parameter int CNT_W = 4
)
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Source and setting
   input wire logic src_tick_i,
   input wire logic [1:0] div_sel_i,
   // Result
   output logic [1:0] div_active_o,
   output logic tick_o
);

   logic [CNT_W-1:0] cnt;

   function automatic logic [CNT_W-1:0] div_mask(input logic [1:0] sel);
      unique case (sel)
         DIV_BY_16: div_mask = {CNT_W{1'b1}};
         DIV_BY_4: div_mask = CNT_W'(4'h3);
         DIV_BY_2: div_mask = CNT_W'(4'h1);
         DIV_BY_1: div_mask = '0;
      endcase
   endfunction : div_mask

   wire logic [CNT_W-1:0] mask = div_mask(div_active_o);
   wire logic at_wrap = src_tick_i && (cnt == {CNT_W{1'b1}});
   wire logic hit = src_tick_i && ((cnt & mask) == mask);

   // A new setting is taken only on the wrap, so all ratios stay phase aligned
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         cnt <= '0;
         div_active_o <= SYSCLK_DIVIDER_RESET;
         tick_o <= 1'b0;
      end
      else
      begin
         if (src_tick_i)
            cnt <= cnt + CNT_W'(1);
         if (at_wrap)
            div_active_o <= div_sel_i;
         tick_o <= hit;
      end
   end

endmodule : pmc_sysclk_div
`default_nettype wire

// >>> logic/pmc_dual_clock_ctrl.sv
// Dual clock selection, oscillator control and power mode sequencing
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Out of reset run in Slow mode from the slow oscillator.
// - Fast internal oscillator and slow internal oscillator are the only clock sources.
// - Fast clock select picks the source; changes only while fast oscillator stop is 0.
// - Fast oscillator stop halts it; alterable only in Slow mode.
// - Hardware rejects abnormal clock control writes.
// - Divider field 00 /16, 01 /4, 10 /2, 11 /1; reset value 11.
// - New divider setting takes effect within sixteen source cycles.
// - Seven-bit trim field, read/write, 00h slowest, 7Fh fastest.
// - Trim value is loaded from the factory configuration word.
// - Writing idle request enters Idle; CPU clock halts, peripherals run.
// - With the gate bit set, Idle stops all peripherals except Timer3 and pins.
// - Idle ends on reset or any enabled interrupt.
// - Writing stop request enters Stop; all clocks halt except an enabled watchdog. Here the watchdog keeps running in Stop only in reset mode 11.
// - Stop ends only on reset or a pin wake-up.
// - Stop request ignored while an enabled external interrupt pin is low.
// - Enabled external pins wake from Stop regardless of global interrupt enable.
// - Each port pin has a wake enable bit, reset disabled.
// - Watchdog reset mode 11 keeps the watchdog running in Idle and Stop.
module pmc_dual_clock_ctrl
(
   // Clock and reset
   input wire logic CLK_I,
   input wire logic RESET_I,
   // Special function register port
   input wire logic [7:0] SFR_ADDR_I,
   input wire logic SFR_WR_I,
   input wire logic [7:0] SFR_WDATA_I,
   output logic [7:0] SFR_RDATA_O,
   // Factory trim from the configuration word
   input wire logic [pmc_pkg::TRIM_WIDTH-1:0] TRIM_CONFIG_WORD_I,
   // Oscillator outputs, asynchronous
   input wire logic FAST_INTERNAL_OSC_I,
   input wire logic SLOW_INTERNAL_OSC_I,
   // Wake sources
   input wire logic [2:0] EXT_INTERRUPT_PIN_I,
   input wire logic [2:0] EXT_INTERRUPT_WAKE_ENABLE_I,
   input wire logic [7:0] PORT_PIN_I,
   input wire logic INT_PENDING_I,
   // Clocking results
   output logic SYSCLK_TICK_O,
   output logic [1:0] SYSCLK_DIVIDER_ACTIVE_O,
   output pmc_pkg::pmc_clk_en_type CLK_EN_O,
   output logic [pmc_pkg::TRIM_WIDTH-1:0] FAST_OSC_TRIM_O,
   output logic [3:0] POWER_MODE_O
);
   import pmc_pkg::*;

   localparam int SYNC_W = 13;

   function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] off);
      addr_hit = (addr == off);
   endfunction : addr_hit

   // Registers
   pmc_state_type state;
   pmc_state_type next_state;
   logic [7:0] power_mode_control_keep;
   logic idle_periph_clock_gate;
   logic fast_osc_stop;
   logic fast_clock_select;
   logic [1:0] sysclk_divider;
   logic [7:0] port_pin_wake_enable;
   logic [7:0] aux_two;
   logic trim_loaded;

   // Pin and oscillator synchronisers
   logic [SYNC_W-1:0] sync_a;
   logic [SYNC_W-1:0] sync_b;
   logic [SYNC_W-1:0] sync_prev;

   always_ff @(posedge CLK_I or posedge RESET_I)
   begin
      if (RESET_I)
      begin
         sync_a <= {SYNC_W{1'b1}};
         sync_b <= {SYNC_W{1'b1}};
         sync_prev <= {SYNC_W{1'b1}};
      end
      else
      begin
         sync_a <= {FAST_INTERNAL_OSC_I, SLOW_INTERNAL_OSC_I,
                    EXT_INTERRUPT_PIN_I, PORT_PIN_I};
         sync_b <= sync_a;
         sync_prev <= sync_b;
      end
   end

   wire logic fast_osc_s = sync_b[12];
   wire logic slow_osc_s = sync_b[11];
   wire logic [2:0] ext_pin_s = sync_b[10:8];
   wire logic [7:0] port_pin_s = sync_b[7:0];
   wire logic fast_rise = fast_osc_s && !sync_prev[12];
   wire logic slow_rise = slow_osc_s && !sync_prev[11];
   wire logic [7:0] port_change = port_pin_s ^ sync_prev[7:0];

   // Mode decode
   wire logic in_run = (state == PM_RUN);
   wire logic in_idle = (state == PM_IDLE);
   wire logic in_stop = (state == PM_STOP);
   wire logic slow_mode = in_run && !fast_clock_select;

   // Register write decode
   wire logic wr_power_mode_control = SFR_WR_I && addr_hit(SFR_ADDR_I, POWER_MODE_CONTROL_ADDR);
   wire logic wr_clk = SFR_WR_I && addr_hit(SFR_ADDR_I, CLOCK_SELECT_CONTROL_ADDR);
   wire logic wr_trim = SFR_WR_I && addr_hit(SFR_ADDR_I, FAST_OSC_TRIM_ADDR);
   wire logic wr_aux = SFR_WR_I && addr_hit(SFR_ADDR_I, AUXILIARY_CONTROL_TWO_ADDR);
   wire logic wr_pwk = SFR_WR_I && addr_hit(SFR_ADDR_I, PORT_PIN_WAKE_ENABLE_ADDR);

   // Clock control write guards
   wire logic want_stop = SFR_WDATA_I[FAST_OSC_STOP_BIT];
   wire logic want_sel = SFR_WDATA_I[FAST_CLOCK_SELECT_BIT];
   wire logic stop_ok = slow_mode;
   wire logic next_fast_osc_stop = (wr_clk && stop_ok) ? want_stop : fast_osc_stop;
   // Select is refused if stop is set now or would be set by this very write
   wire logic sel_ok = !fast_osc_stop && !next_fast_osc_stop;
   wire logic next_fast_clock_select = (wr_clk && sel_ok) ? want_sel
                                                           : fast_clock_select;

   // Wake conditions; global interrupt enable is deliberately not looked at
   wire logic [2:0] ext_low_en = ~ext_pin_s & EXT_INTERRUPT_WAKE_ENABLE_I;
   wire logic ext_wake = |ext_low_en;
   wire logic port_wake = |(port_change & port_pin_wake_enable);
   wire logic pin_wake = ext_wake || port_wake;
   wire logic stop_blocked = ext_wake;

   // Power mode requests
   wire logic req_stop = wr_power_mode_control && SFR_WDATA_I[STOP_REQUEST_BIT] && !stop_blocked;
   wire logic req_idle = wr_power_mode_control && SFR_WDATA_I[IDLE_REQUEST_BIT];

   always_comb
   begin
      next_state = state;
      unique case (state)
         PM_RUN:
         begin
            if (req_stop)
               next_state = PM_STOP;
            else if (req_idle)
               next_state = PM_IDLE;
         end
         PM_IDLE:
         begin
            if (INT_PENDING_I)
               next_state = PM_RUN;
         end
         PM_STOP:
         begin
            if (pin_wake)
               next_state = PM_RUN;
         end
         default:
            next_state = PM_RUN;
      endcase
   end

   wire logic next_run = (next_state == PM_RUN);
   wire logic next_idle = (next_state == PM_IDLE);
   wire logic next_stop = (next_state == PM_STOP);

   // Clock enables follow the state being entered, so they line up with it
   wire logic [1:0] wdt_mode = aux_two[WATCHDOG_RESET_MODE_LSB +: 2];
   pmc_clk_en_type next_clk_en;
   assign next_clk_en.cpu = next_run;
   assign next_clk_en.periph = next_run || (next_idle && !idle_periph_clock_gate);
   assign next_clk_en.timer3 = !next_stop;
   assign next_clk_en.wdt = wdt_mode[1] && (next_run || (wdt_mode == WATCHDOG_ALWAYS));
   assign next_clk_en.fast_osc = !next_fast_osc_stop && !next_stop;
   assign next_clk_en.slow_osc = !next_stop;

   wire logic [3:0] next_power_mode = next_stop ? MODE_STOP :
                                      next_idle ? MODE_IDLE :
                                      next_fast_clock_select ? MODE_FAST : MODE_SLOW;

   // Source tick for the divider; only the selected running oscillator counts
   wire logic fast_tick = fast_rise && !fast_osc_stop;
   wire logic src_tick = !in_stop && (fast_clock_select ? fast_tick : slow_rise);

   // Read back
   wire logic [7:0] power_mode_control_rd = power_mode_control_keep | {6'h00, in_stop, in_idle};
   wire logic [7:0] clk_rd = {3'h0, idle_periph_clock_gate, fast_osc_stop,
                              fast_clock_select, sysclk_divider};
   logic [7:0] rd_mux;

   always_comb
   begin
      rd_mux = 8'h00;
      if (addr_hit(SFR_ADDR_I, POWER_MODE_CONTROL_ADDR))
         rd_mux = power_mode_control_rd;
      else if (addr_hit(SFR_ADDR_I, CLOCK_SELECT_CONTROL_ADDR))
         rd_mux = clk_rd;
      else if (addr_hit(SFR_ADDR_I, FAST_OSC_TRIM_ADDR))
         rd_mux = {1'b0, FAST_OSC_TRIM_O};
      else if (addr_hit(SFR_ADDR_I, AUXILIARY_CONTROL_TWO_ADDR))
         rd_mux = aux_two;
      else if (addr_hit(SFR_ADDR_I, PORT_PIN_WAKE_ENABLE_ADDR))
         rd_mux = port_pin_wake_enable;
   end

   // Mode state and power mode control
   always_ff @(posedge CLK_I or posedge RESET_I)
   begin
      if (RESET_I)
      begin
         state <= PM_RUN;
         power_mode_control_keep <= POWER_MODE_CONTROL_RESET;
      end
      else
      begin
         state <= next_state;
         if (wr_power_mode_control)
            power_mode_control_keep <= SFR_WDATA_I & POWER_MODE_KEEP_MASK;
      end
   end

   // Clock select control
   always_ff @(posedge CLK_I or posedge RESET_I)
   begin
      if (RESET_I)
      begin
         idle_periph_clock_gate <= 1'b0;
         fast_osc_stop <= 1'b0;
         fast_clock_select <= 1'b0;
         sysclk_divider <= SYSCLK_DIVIDER_RESET;
      end
      else
      begin
         fast_osc_stop <= next_fast_osc_stop;
         fast_clock_select <= next_fast_clock_select;
         if (wr_clk)
         begin
            idle_periph_clock_gate <= SFR_WDATA_I[IDLE_PERIPH_CLOCK_GATE_BIT];
            sysclk_divider <= SFR_WDATA_I[SYSCLK_DIVIDER_LSB +: 2];
         end
      end
   end

   // Auxiliary and wake enable registers
   always_ff @(posedge CLK_I or posedge RESET_I)
   begin
      if (RESET_I)
      begin
         aux_two <= AUXILIARY_CONTROL_TWO_RESET;
         port_pin_wake_enable <= PORT_PIN_WAKE_ENABLE_RESET;
      end
      else
      begin
         if (wr_aux)
            aux_two <= SFR_WDATA_I;
         if (wr_pwk)
            port_pin_wake_enable <= SFR_WDATA_I;
      end
   end

   // Trim is caught from the configuration word on the first edge after release;
   // a software write in that same cycle is lost to the factory value
   always_ff @(posedge CLK_I or posedge RESET_I)
   begin
      if (RESET_I)
      begin
         trim_loaded <= 1'b0;
         FAST_OSC_TRIM_O <= '0;
      end
      else if (!trim_loaded)
      begin
         trim_loaded <= 1'b1;
         FAST_OSC_TRIM_O <= TRIM_CONFIG_WORD_I;
      end
      else if (wr_trim)
         FAST_OSC_TRIM_O <= SFR_WDATA_I[TRIM_WIDTH-1:0];
   end

   // Registered outputs
   always_ff @(posedge CLK_I or posedge RESET_I)
   begin
      if (RESET_I)
      begin
         SFR_RDATA_O <= 8'h00;
         CLK_EN_O <= CLK_EN_RESET;
         POWER_MODE_O <= MODE_SLOW;
      end
      else
      begin
         SFR_RDATA_O <= rd_mux;
         CLK_EN_O <= next_clk_en;
         POWER_MODE_O <= next_power_mode;
      end
   end

   pmc_sysclk_div #(
      .CNT_W(4)
   ) pmc_sysclk_div_i (
      .clk_i(CLK_I),
      .rst_i(RESET_I),
      .src_tick_i(src_tick),
      .div_sel_i(sysclk_divider),
      .div_active_o(SYSCLK_DIVIDER_ACTIVE_O),
      .tick_o(SYSCLK_TICK_O)
   );

endmodule : pmc_dual_clock_ctrl
`default_nettype wire

// >>> bench/pmc_checker.sv
// Concurrent checks on the ports of the clock and power mode block
`timescale 1ns/1ps
`default_nettype none
module pmc_checker
   import pmc_pkg::*;
(
   // Clock and reset
   input wire logic CLK_I,
   input wire logic RESET_I,
   // Register writes
   input wire logic [7:0] SFR_ADDR_I,
   input wire logic SFR_WR_I,
   input wire logic [7:0] SFR_WDATA_I,
   // Wake sources
   input wire logic [2:0] EXT_INTERRUPT_PIN_I,
   input wire logic [2:0] EXT_INTERRUPT_WAKE_ENABLE_I,
   input wire logic [7:0] PORT_PIN_I,
   input wire logic INT_PENDING_I,
   // Results
   input wire pmc_pkg::pmc_clk_en_type CLK_EN_O,
   input wire logic [pmc_pkg::TRIM_WIDTH-1:0] FAST_OSC_TRIM_O,
   input wire logic [3:0] POWER_MODE_O
);
   logic quiet;
   logic run;
   logic [2:0] q_cnt;
   assign quiet = &(EXT_INTERRUPT_PIN_I | ~EXT_INTERRUPT_WAKE_ENABLE_I);
   assign run = (POWER_MODE_O == MODE_FAST) || (POWER_MODE_O == MODE_SLOW);
   // Pin events take several edges through the synchronisers, so quiet time is counted
   always_ff @(posedge CLK_I or posedge RESET_I)
   begin
      if (RESET_I)
         q_cnt <= 3'h0;
      else if (!quiet || (PORT_PIN_I != $past(PORT_PIN_I)))
         q_cnt <= 3'h0;
      else if (q_cnt != 3'h7)
         q_cnt <= q_cnt + 3'h1;
   end
   default clocking cb @(posedge CLK_I);
   endclocking
   default disable iff (RESET_I);
   sequence s_mode_wr(logic [1:0] req);
      SFR_WR_I && (SFR_ADDR_I == POWER_MODE_CONTROL_ADDR) && (SFR_WDATA_I[1:0] == req) && run;
   endsequence
   sequence s_quiet3;
      quiet && $past(quiet) && $past(quiet, 2) && $past(quiet, 3);
   endsequence
   sequence s_held3;
      !quiet && !$past(quiet) && !$past(quiet, 2) && !$past(quiet, 3);
   endsequence
   property p_reset_slow;
      $fell(RESET_I) |-> POWER_MODE_O == MODE_SLOW && CLK_EN_O == CLK_EN_RESET;
   endproperty
   a_reset_slow: assert property (p_reset_slow) else $error("not slow after reset");
   property p_idle_entry;
      s_mode_wr(2'h1) |=> POWER_MODE_O == MODE_IDLE && !CLK_EN_O.cpu && CLK_EN_O.timer3;
   endproperty
   a_idle_entry: assert property (p_idle_entry) else $error("idle not entered");
   property p_stop_entry;
      s_mode_wr(2'h2) ##0 s_quiet3 |=> POWER_MODE_O == MODE_STOP;
   endproperty
   a_stop_entry: assert property (p_stop_entry) else $error("stop not entered");
   property p_stop_refused;
      s_mode_wr(2'h2) ##0 s_held3 |=> POWER_MODE_O != MODE_STOP;
   endproperty
   a_stop_refused: assert property (p_stop_refused) else $error("stop taken with pin low");
   property p_stop_clocks;
      POWER_MODE_O == MODE_STOP |-> !(CLK_EN_O.cpu || CLK_EN_O.periph || CLK_EN_O.fast_osc);
   endproperty
   a_stop_clocks: assert property (p_stop_clocks) else $error("clock running in stop");
   property p_stop_holds;
      POWER_MODE_O == MODE_STOP && quiet && q_cnt == 3'h7 |=> POWER_MODE_O == MODE_STOP;
   endproperty
   a_stop_holds: assert property (p_stop_holds) else $error("stop left without pin");
   property p_pin_wake;
      POWER_MODE_O == MODE_STOP && !quiet |-> ##[1:6] run;
   endproperty
   a_pin_wake: assert property (p_pin_wake) else $error("pin did not wake stop");
   property p_idle_wake;
      POWER_MODE_O == MODE_IDLE && INT_PENDING_I |-> ##[1:3] run && CLK_EN_O.cpu;
   endproperty
   a_idle_wake: assert property (p_idle_wake) else $error("idle not left");
   property p_trim_wr;
      SFR_WR_I && SFR_ADDR_I == FAST_OSC_TRIM_ADDR |=> FAST_OSC_TRIM_O == $past(SFR_WDATA_I[6:0]);
   endproperty
   a_trim_wr: assert property (p_trim_wr) else $error("trim write lost");
endmodule : pmc_checker
bind pmc_dual_clock_ctrl pmc_checker pmc_checker_i (.CLK_I(CLK_I), .RESET_I(RESET_I),
   .SFR_ADDR_I(SFR_ADDR_I), .SFR_WR_I(SFR_WR_I), .SFR_WDATA_I(SFR_WDATA_I),
   .EXT_INTERRUPT_PIN_I(EXT_INTERRUPT_PIN_I), .PORT_PIN_I(PORT_PIN_I),
   .EXT_INTERRUPT_WAKE_ENABLE_I(EXT_INTERRUPT_WAKE_ENABLE_I), .INT_PENDING_I(INT_PENDING_I),
   .CLK_EN_O(CLK_EN_O), .FAST_OSC_TRIM_O(FAST_OSC_TRIM_O), .POWER_MODE_O(POWER_MODE_O));
`default_nettype wire

// >>> bench/pmc_dual_clock_ctrl_tb_top.sv
// Self-checking bench for the clock and power mode block
`timescale 1ns/1ps
`default_nettype none
module pmc_dual_clock_ctrl_tb_top;
   import pmc_pkg::*;
   logic CLK_I = 1'b0;
   logic RESET_I = 1'b1;
   logic [7:0] addr = 8'h00;
   logic we = 1'b0;
   logic [7:0] wdata = 8'h00;
   logic [2:0] pin = 3'h7;
   logic [2:0] wen = 3'h0;
   logic [7:0] port = 8'h00;
   logic pend = 1'b0;
   logic [3:0] osc = 4'h0;
   logic [7:0] rdata;
   logic tick;
   logic [1:0] div_act;
   pmc_clk_en_type clk_en;
   logic [6:0] trim;
   logic [3:0] mode;
   int error_cnt = 0;
   int n_checks = 0;
   int cnt;
   int exp_t;
   logic [7:0] ra [6] = '{8'h87, 8'hd8, 8'hf7, 8'h96, 8'hf6, 8'h55};
   logic [7:0] rv [6] = '{8'h00, 8'h03, 8'h06, 8'h00, 8'h5a, 8'h00};
   always #12.5 CLK_I = ~CLK_I;
   // Oscillators scaled far down to keep the run short; only their edges matter
   always @(posedge CLK_I)
      osc <= osc + 4'h1;
   pmc_dual_clock_ctrl pmc_dual_clock_ctrl_i (.CLK_I(CLK_I), .RESET_I(RESET_I),
      .SFR_ADDR_I(addr), .SFR_WR_I(we), .SFR_WDATA_I(wdata), .SFR_RDATA_O(rdata),
      .TRIM_CONFIG_WORD_I(7'h5a), .FAST_INTERNAL_OSC_I(osc[1]), .SLOW_INTERNAL_OSC_I(osc[2]),
      .EXT_INTERRUPT_PIN_I(pin), .EXT_INTERRUPT_WAKE_ENABLE_I(wen), .PORT_PIN_I(port),
      .INT_PENDING_I(pend), .SYSCLK_TICK_O(tick), .SYSCLK_DIVIDER_ACTIVE_O(div_act),
      .CLK_EN_O(clk_en), .FAST_OSC_TRIM_O(trim), .POWER_MODE_O(mode));
   task automatic wrap_up();
      $display("Checks %0d, mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : wrap_up
   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      n_checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   function automatic logic [7:0] seen(input string name);
      return (name == "mode") ? {4'h0, mode} : {6'h0, div_act};
   endfunction : seen
   task automatic settle(input int n);
      repeat (n) @(posedge CLK_I);
      #1;
   endtask : settle
   // Bounded wait; running out of the bound ends the run
   task automatic wait_eq(input string name, input logic [7:0] exp, input int bound);
      cnt = 0;
      while (seen(name) !== exp && cnt < bound)
      begin
         settle(1);
         cnt++;
      end
      chk(name, exp, seen(name));
      if (seen(name) !== exp)
         wrap_up();
   endtask : wait_eq
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge CLK_I);
      addr <= a;
      wdata <= d;
      we <= 1'b1;
      @(posedge CLK_I);
      we <= 1'b0;
      #1;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge CLK_I);
      addr <= a;
      settle(1);
      chk($sformatf("read %h", a), exp, rdata);
   endtask : rd
   task automatic chk_mode(input logic [3:0] exp);
      chk("mode", {4'h0, exp}, {4'h0, mode});
   endtask : chk_mode
   initial
   begin
      repeat (5) @(posedge CLK_I);
      RESET_I <= 1'b0;
      settle(1);
      chk_mode(MODE_SLOW);
      chk("reset enables", {2'h0, CLK_EN_RESET}, {2'h0, clk_en});
      chk("divider in force", {6'h0, DIV_BY_1}, seen("div"));
      chk("trim", 8'h5a, {1'b0, trim});
      foreach (ra[k])
         rd(ra[k], rv[k]);
      wr(CLOCK_SELECT_CONTROL_ADDR, 8'h0b);
      rd(CLOCK_SELECT_CONTROL_ADDR, 8'h0b);
      chk("fast osc enable", 8'h00, {7'h0, clk_en.fast_osc});
      wr(CLOCK_SELECT_CONTROL_ADDR, 8'h0f);
      rd(CLOCK_SELECT_CONTROL_ADDR, 8'h0b);
      wr(CLOCK_SELECT_CONTROL_ADDR, 8'h03);
      wait_eq("div", {6'h0, DIV_BY_1}, 140);
      wr(CLOCK_SELECT_CONTROL_ADDR, 8'h07);
      rd(CLOCK_SELECT_CONTROL_ADDR, 8'h07);
      chk_mode(MODE_FAST);
      wr(CLOCK_SELECT_CONTROL_ADDR, 8'h0f);
      rd(CLOCK_SELECT_CONTROL_ADDR, 8'h07);
      wr(CLOCK_SELECT_CONTROL_ADDR, 8'h03);
      chk_mode(MODE_SLOW);
      wr(FAST_OSC_TRIM_ADDR, 8'hff);
      rd(FAST_OSC_TRIM_ADDR, 8'h7f);
      chk("trim", 8'h7f, {1'b0, trim});
      // Last pass switches to the fast source once the divider has settled
      for (int i = 0; i < 5; i++)
      begin
         wr(CLOCK_SELECT_CONTROL_ADDR, (i == 4) ? 8'h07 : 8'(i));
         wait_eq("div", (i == 4) ? 8'h03 : 8'(i), 140);
         exp_t = (i == 0) ? 2 : (i == 4) ? 64 : (32 >> (3 - i));
         cnt = 0;
         repeat (256)
         begin
            settle(1);
            if (tick === 1'b1)
               cnt++;
         end
         n_checks++;
         if (cnt < exp_t - 1 || cnt > exp_t + 1)
         begin
            error_cnt++;
            $display("CHECK FAILED ticks code %0d expected %0d seen %0d", i, exp_t, cnt);
         end
      end
      for (int g = 0; g < 2; g++)
      begin
         wr(CLOCK_SELECT_CONTROL_ADDR, g ? 8'h13 : 8'h03);
         wr(POWER_MODE_CONTROL_ADDR, 8'h01);
         chk_mode(MODE_IDLE);
         chk("idle enables", {6'h0, ~g[0], 1'b1}, {5'h0, clk_en.cpu, clk_en.periph, clk_en.timer3});
         rd(POWER_MODE_CONTROL_ADDR, 8'h01);
         @(posedge CLK_I);
         pend <= 1'b1;
         wait_eq("mode", {4'h0, MODE_SLOW}, 4);
         @(posedge CLK_I);
         pend <= 1'b0;
         rd(POWER_MODE_CONTROL_ADDR, 8'h00);
      end
      wr(AUXILIARY_CONTROL_TWO_ADDR, 8'hc6);
      wr(POWER_MODE_CONTROL_ADDR, 8'h02);
      chk_mode(MODE_STOP);
      chk("stop enables", 8'h04, {2'h0, clk_en});
      @(posedge CLK_I);
      pend <= 1'b1;
      pin <= 3'h5;
      settle(10);
      chk_mode(MODE_STOP);
      @(posedge CLK_I);
      pend <= 1'b0;
      wen <= 3'h2;
      wait_eq("mode", {4'h0, MODE_SLOW}, 8);
      for (int n = 0; n < 3; n++)
      begin
         @(posedge CLK_I);
         pin <= ~(3'h1 << n);
         wen <= 3'h1 << n;
         settle(4);
         wr(POWER_MODE_CONTROL_ADDR, 8'h02);
         settle(2);
         chk_mode(MODE_SLOW);
      end
      @(posedge CLK_I);
      pin <= 3'h7;
      wen <= 3'h0;
      wr(AUXILIARY_CONTROL_TWO_ADDR, 8'h06);
      wr(PORT_PIN_WAKE_ENABLE_ADDR, 8'h08);
      rd(PORT_PIN_WAKE_ENABLE_ADDR, 8'h08);
      wr(POWER_MODE_CONTROL_ADDR, 8'h02);
      chk("stop enables", 8'h00, {2'h0, clk_en});
      @(posedge CLK_I);
      port <= 8'h04;
      settle(10);
      chk_mode(MODE_STOP);
      @(posedge CLK_I);
      port <= 8'h0c;
      wait_eq("mode", {4'h0, MODE_SLOW}, 8);
      // Watchdog mode 10 runs it only while the CPU runs
      wr(AUXILIARY_CONTROL_TWO_ADDR, 8'h86);
      settle(1);
      chk("wdt enable", 8'h01, {7'h0, clk_en.wdt});
      wrap_up();
   end
endmodule : pmc_dual_clock_ctrl_tb_top
`default_nettype wire
